/* File: ppp_backend_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// memory backend: slow page sink, delayed op completion
// ****************************************
module ppp_backend_model (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_op_start,
  input wire logic i_pb_valid,
  input wire logic [15:0] i_mem_addr,
  output logic o_op_done,
  output logic o_pb_ready,
  output logic [15:0] o_mem_rd_data
);
  logic [4:0] op_cnt_r;
  logic [3:0] stall_r;
  // read word scrambled from the address so byte swaps show up
  assign o_mem_rd_data = i_mem_addr ^ 16'hA55A;
  // sink stalls seven cycles before taking each word
  assign o_pb_ready = (stall_r == 4'h7);
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      op_cnt_r <= 5'h00;
      o_op_done <= 1'b0;
    end else begin
      o_op_done <= (op_cnt_r == 5'h01);
      if (i_op_start) begin
        op_cnt_r <= 5'h14;
      end else if (op_cnt_r != 5'h00) begin
        op_cnt_r <= op_cnt_r - 5'h01;
      end
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_pb_valid || o_pb_ready) begin
      stall_r <= 4'h0;
    end else begin
      stall_r <= stall_r + 4'h1;
    end
  end
endmodule : ppp_backend_model
`default_nettype wire

/* File: ppp_pair_buf.sv */
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer: an output stage plus one spare, so a stall never drops a word
module ppp_pair_buf #(parameter int W = 8) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  ppp_stream_if.snk s_in,
  ppp_stream_if.src s_out
);
  logic skid_v_r;
  logic [W-1:0] skid_d_r;
  logic push;

  // ready comes from a flop, so the source sees no combinational path
  assign s_in.ready = ~skid_v_r;
  assign push = s_in.valid & ~skid_v_r;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_out.valid <= 1'b0;
      s_out.data <= '0;
      skid_v_r <= 1'b0;
      skid_d_r <= '0;
    end else if (!s_out.valid || s_out.ready) begin
      if (skid_v_r) begin
        s_out.data <= skid_d_r;
        s_out.valid <= 1'b1;
        skid_v_r <= 1'b0;
      end else begin
        s_out.data <= s_in.data;
        s_out.valid <= push;
      end
    end else if (push) begin
      skid_d_r <= s_in.data;
      skid_v_r <= 1'b1;
    end
  end
endmodule : ppp_pair_buf
`default_nettype wire

/* File: ppp_pkg.sv */
// Operation
// - high fuse bits 7,6,5: debug (1), boundary port (0), serial prog (0)
// - high fuse: watchdog 4, eeprom keep 3, boot size 2:1 (00), vector 0
// - serial prog enable fuse hidden and untouched in serial programming mode
// - low fuse: clock div8 at 7 (0), clock output at 6 (1)
// - low fuse: startup 5:4 = 10, clock source 3:0 = 0010
// - chip erase never changes fuse bits
// - fuse writes refused once lock bit one is programmed
// - fuses captured on programming entry; changes act only after exit
// - eeprom keep fuse takes effect as soon as programmed
// - fuses also captured at power-up in normal mode
// - three id bytes at 0x000..0x002, readable even when locked
// - calibration byte at high byte of id 0x000, copied to trim on reset
// - ready_busy_n low while an operation runs, high when ready
// - data bus driven only while output enable is low
// - byte selects choose low, high or lock byte
// - clock pin rising edge acts on action code: addr, data, command, idle
// - command byte decode; write or output enable strobe executes it
// - flash 128 pages of 64 words, word bits 5:0, page 12:6
// - eeprom 128 pages of 4 bytes, byte bits 1:0, page 8:2
// - entry pin change within 100 ns of high voltage blocks entry
// - fuse reads return 0 for programmed, 1 for unprogrammed
// - page latch pulse stores loaded data at addressed word
// - command and address held until overwritten
package ppp_pkg;
  localparam int CLK_NS = 8;
  localparam int ENTRY_HOLD_NS = 100;
  localparam logic [3:0] ENTRY_HOLD_CYC = 4'((ENTRY_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam int FUSE_WR_NS = 2000;
  localparam logic [7:0] FUSE_WR_CYC = 8'(FUSE_WR_NS / CLK_NS);
  localparam int DEBUG_EN_BIT = 7;
  localparam int BOUNDARY_EN_BIT = 6;
  localparam int SERIAL_PROG_BIT = 5;
  localparam int WDT_FORCED_BIT = 4;
  localparam int EEPROM_KEEP_BIT = 3;
  localparam int BOOT_SIZE_LSB = 1;
  localparam int RESET_VEC_BIT = 0;
  localparam int CLK_DIV8_BIT = 7;
  localparam int CLK_OUT_BIT = 6;
  localparam int STARTUP_LSB = 4;
  localparam int CLK_SRC_LSB = 0;
  localparam int LOCK1_BIT = 0;
  localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
  localparam logic [7:0] FUSE_LOW_RST = 8'h62;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [7:0] SIG_BYTE0 = 8'h5A; // arbitrary value
  localparam logic [7:0] SIG_BYTE1 = 8'hA5; // arbitrary value
  localparam logic [7:0] SIG_BYTE2 = 8'h3C; // arbitrary value
  localparam logic [7:0] CAL_BYTE = 8'h80;
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
  localparam int WORD_IDX_W = 6;
  localparam int FLASH_PAGE_LSB = 6;
  localparam int EE_BYTE_W = 2;
  localparam int EE_PAGE_LSB = 2;
  localparam int PAGE_W = 7;
  localparam int PB_W = WORD_IDX_W + 16;
  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_FLASH_PAGE, OP_EE_PAGE} ppp_op_e;
endpackage : ppp_pkg

/* File: ppp_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ppp_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ppp_stream_if
`default_nettype wire

/* File: ppp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ppp_top (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hv_reset,
  input wire logic i_clock_input_pin,
  input wire logic i_action_code_bit0,
  input wire logic i_action_code_bit1,
  input wire logic i_byte_select_one,
  input wire logic i_byte_select_two,
  input wire logic i_page_latch_strobe,
  input wire logic i_wr_n,
  input wire logic i_oe_n,
  input wire logic [7:0] i_data,
  input wire logic i_serial_prog_mode,
  input wire logic [15:0] i_mem_rd_data,
  input wire logic i_op_done,
  input wire logic i_pb_ready,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_ready_busy_n,
  output logic o_prog_mode,
  output logic [7:0] o_fuse_high_eff,
  output logic [7:0] o_fuse_low_eff,
  output logic o_eeprom_keep,
  output logic o_clock_output_en,
  output logic [7:0] o_rc_trim_register,
  output logic o_op_start,
  output ppp_pkg::ppp_op_e o_op_kind,
  output logic [6:0] o_op_page,
  output logic [15:0] o_mem_addr,
  output logic o_pb_valid,
  output logic [ppp_pkg::PB_W-1:0] o_pb_data
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {ENT_OFF, ENT_WAIT, ENT_ON, ENT_FAIL} ppp_ent_e;
  typedef enum logic [1:0] {ST_IDLE, ST_BACKEND, ST_TIMER} ppp_st_e;

  ppp_ent_e ent_st_r;
  ppp_st_e op_st_r;
  logic [3:0] ent_cnt_r;
  logic [7:0] tmr_r;
  logic prog_mode_r, mode_seen_r, pwr_cap_r;
  logic hv_prev_r, xtal_prev_r, wr_prev_r, page_latch_strobe_prev_r;
  logic [7:0] cmd_r, data_lo_r, data_hi_r, lock_r;
  logic [15:0] addr_r;
  logic [7:0] fuse_high_r, fuse_low_r, eff_high_r, eff_low_r;
  logic pend_r, rdy_r, oe_r, keep_r, clock_output_fuse_r, start_r;
  logic [7:0] dout_r, trim_r, rd_byte;
  ppp_pkg::ppp_op_e kind_r;
  logic [6:0] page_r;
  logic [3:0] pins;
  logic [1:0] act;
  logic xtal_rise, wr_fall, page_rise, wr_go;

  assign pins = {i_page_latch_strobe, i_action_code_bit1, i_action_code_bit0, i_byte_select_one};
  assign act = {i_action_code_bit1, i_action_code_bit0};
  assign xtal_rise = i_clock_input_pin & ~xtal_prev_r;
  assign wr_fall = ~i_wr_n & wr_prev_r;
  assign page_rise = i_page_latch_strobe & ~page_latch_strobe_prev_r;
  assign wr_go = wr_fall & prog_mode_r & (op_st_r == ST_IDLE) & ~pend_r;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      hv_prev_r <= 1'b0;
      xtal_prev_r <= 1'b0;
      wr_prev_r <= 1'b1;
      page_latch_strobe_prev_r <= 1'b0;
    end else begin
      hv_prev_r <= i_hv_reset;
      xtal_prev_r <= i_clock_input_pin;
      wr_prev_r <= i_wr_n;
      page_latch_strobe_prev_r <= i_page_latch_strobe;
    end
  end

  // ****************************************
  // programming-mode entry
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ent_st_r <= ENT_OFF;
      ent_cnt_r <= 4'h0;
      prog_mode_r <= 1'b0;
    end else begin
      case (ent_st_r)
        ENT_OFF: begin
          if (i_hv_reset && !hv_prev_r) begin
            ent_st_r <= (pins == 4'h0) ? ENT_WAIT : ENT_FAIL;
            ent_cnt_r <= 4'h1;
          end
        end
        ENT_WAIT: begin
          if (!i_hv_reset) begin
            ent_st_r <= ENT_OFF;
          end else if (pins != 4'h0) begin
            ent_st_r <= ENT_FAIL;
          end else if (ent_cnt_r == ppp_pkg::ENTRY_HOLD_CYC) begin
            ent_st_r <= ENT_ON;
            prog_mode_r <= 1'b1;
          end else begin
            ent_cnt_r <= ent_cnt_r + 4'h1;
          end
        end
        ENT_ON: begin
          if (!i_hv_reset) begin
            ent_st_r <= ENT_OFF;
            prog_mode_r <= 1'b0;
          end
        end
        ENT_FAIL: begin
          // a failed entry waits for the high voltage to drop before retrying
          if (!i_hv_reset) begin
            ent_st_r <= ENT_OFF;
          end
        end
        default: begin
          ent_st_r <= ENT_OFF;
          prog_mode_r <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // effective fuse capture
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      eff_high_r <= ppp_pkg::FUSE_HIGH_RST;
      eff_low_r <= ppp_pkg::FUSE_LOW_RST;
      mode_seen_r <= 1'b0;
      pwr_cap_r <= 1'b1;
    end else begin
      mode_seen_r <= prog_mode_r;
      pwr_cap_r <= 1'b0;
      if ((pwr_cap_r && !prog_mode_r) || (prog_mode_r != mode_seen_r)) begin
        eff_high_r <= fuse_high_r;
        eff_low_r <= fuse_low_r;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      keep_r <= 1'b0;
      clock_output_fuse_r <= 1'b0;
      trim_r <= ppp_pkg::CAL_BYTE;
    end else begin
      keep_r <= ~fuse_high_r[ppp_pkg::EEPROM_KEEP_BIT];
      clock_output_fuse_r <= ~eff_low_r[ppp_pkg::CLK_OUT_BIT];
    end
  end

  // ****************************************
  // loads on the clock input pin
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cmd_r <= 8'h00;
      addr_r <= 16'h0000;
      data_lo_r <= 8'hFF;
      data_hi_r <= 8'hFF;
    end else if (xtal_rise && prog_mode_r) begin
      case (act)
        ppp_pkg::ACT_ADDR: begin
          if (i_byte_select_one) begin
            addr_r[15:8] <= i_data;
          end else begin
            addr_r[7:0] <= i_data;
          end
        end
        ppp_pkg::ACT_DATA: begin
          if (i_byte_select_one) begin
            data_hi_r <= i_data;
          end else begin
            data_lo_r <= i_data;
          end
        end
        ppp_pkg::ACT_CMD: cmd_r <= i_data;
        default: cmd_r <= cmd_r;
      endcase
    end
  end

  // ****************************************
  // page latch into the buffer
  // ****************************************
  ppp_stream_if #(.W(ppp_pkg::PB_W)) pb_in ();
  ppp_stream_if #(.W(ppp_pkg::PB_W)) pb_out ();

  // eeprom uses only the low byte index bits; flash uses all six
  assign pb_in.valid = pend_r;
  assign pb_in.data = (cmd_r == ppp_pkg::CMD_WR_EEPROM) ?
    {4'h0, addr_r[ppp_pkg::EE_BYTE_W-1:0], 8'h00, data_lo_r} :
    {addr_r[ppp_pkg::WORD_IDX_W-1:0], data_hi_r, data_lo_r};
  assign pb_out.ready = i_pb_ready;

  ppp_pair_buf #(.W(ppp_pkg::PB_W)) u_buf (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .s_in(pb_in),
    .s_out(pb_out)
  );

  // a latch pulse seen while the buffer is full is held and shows as busy
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pend_r <= 1'b0;
    end else if (page_rise && prog_mode_r) begin
      pend_r <= 1'b1;
    end else if (pb_in.ready) begin
      pend_r <= 1'b0;
    end
  end

  // ****************************************
  // command execution
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      op_st_r <= ST_IDLE;
      tmr_r <= 8'h00;
      start_r <= 1'b0;
      kind_r <= ppp_pkg::OP_NONE;
      page_r <= 7'h00;
      fuse_high_r <= ppp_pkg::FUSE_HIGH_RST;
      fuse_low_r <= ppp_pkg::FUSE_LOW_RST;
      lock_r <= ppp_pkg::LOCK_RST;
    end else begin
      start_r <= 1'b0;
      case (op_st_r)
        ST_IDLE: begin
          if (wr_go) begin
            op_st_r <= ST_TIMER;
            tmr_r <= ppp_pkg::FUSE_WR_CYC;
            case (cmd_r)
              ppp_pkg::CMD_CHIP_ERASE: begin
                op_st_r <= ST_BACKEND;
                start_r <= 1'b1;
                kind_r <= ppp_pkg::OP_ERASE;
              end
              ppp_pkg::CMD_WR_FLASH: begin
                op_st_r <= ST_BACKEND;
                start_r <= 1'b1;
                kind_r <= ppp_pkg::OP_FLASH_PAGE;
                page_r <= addr_r[ppp_pkg::FLASH_PAGE_LSB +: ppp_pkg::PAGE_W];
              end
              ppp_pkg::CMD_WR_EEPROM: begin
                op_st_r <= ST_BACKEND;
                start_r <= 1'b1;
                kind_r <= ppp_pkg::OP_EE_PAGE;
                page_r <= addr_r[ppp_pkg::EE_PAGE_LSB +: ppp_pkg::PAGE_W];
              end
              ppp_pkg::CMD_WR_FUSE: begin
                if (lock_r[ppp_pkg::LOCK1_BIT]) begin
                  case ({i_byte_select_two, i_byte_select_one})
                    2'b00: fuse_low_r <= data_lo_r;
                    2'b01: begin
                      fuse_high_r <= data_lo_r;
                      if (i_serial_prog_mode) begin
                        fuse_high_r[ppp_pkg::SERIAL_PROG_BIT] <=
                          fuse_high_r[ppp_pkg::SERIAL_PROG_BIT];
                      end
                    end
                    default: fuse_low_r <= fuse_low_r;
                  endcase
                end
              end
              // lock writes only move bits toward programmed; chip erase sets them back
              ppp_pkg::CMD_WR_LOCK: lock_r <= lock_r & data_lo_r;
              default: op_st_r <= ST_IDLE;
            endcase
          end
        end
        ST_BACKEND: begin
          if (i_op_done) begin
            op_st_r <= ST_IDLE;
            if (kind_r == ppp_pkg::OP_ERASE) begin
              lock_r <= ppp_pkg::LOCK_RST;
            end
          end
        end
        ST_TIMER: begin
          if (tmr_r == 8'h01) begin
            op_st_r <= ST_IDLE;
          end
          tmr_r <= tmr_r - 8'h01;
        end
        default: op_st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdy_r <= 1'b1;
    end else begin
      rdy_r <= (op_st_r == ST_IDLE) & ~wr_go & ~pend_r;
    end
  end

  // ****************************************
  // read-back onto the data bus
  // ****************************************
  always_comb begin
    rd_byte = ppp_pkg::BLANK_BYTE;
    case (cmd_r)
      ppp_pkg::CMD_RD_SIG: begin
        if (i_byte_select_one) begin
          rd_byte = (addr_r[7:0] == 8'h00) ? ppp_pkg::CAL_BYTE : ppp_pkg::BLANK_BYTE;
        end else if (addr_r[7:0] == 8'h00) begin
          rd_byte = ppp_pkg::SIG_BYTE0;
        end else if (addr_r[7:0] == 8'h01) begin
          rd_byte = ppp_pkg::SIG_BYTE1;
        end else if (addr_r[7:0] == 8'h02) begin
          rd_byte = ppp_pkg::SIG_BYTE2;
        end
      end
      ppp_pkg::CMD_RD_FUSE: begin
        case ({i_byte_select_two, i_byte_select_one})
          2'b00: rd_byte = fuse_low_r;
          2'b11: begin
            rd_byte = fuse_high_r;
            if (i_serial_prog_mode) begin
              rd_byte[ppp_pkg::SERIAL_PROG_BIT] = 1'b1;
            end
          end
          2'b01: rd_byte = lock_r;
          default: rd_byte = ppp_pkg::BLANK_BYTE;
        endcase
      end
      ppp_pkg::CMD_RD_FLASH: rd_byte = i_byte_select_one ? i_mem_rd_data[15:8] : i_mem_rd_data[7:0];
      ppp_pkg::CMD_RD_EEPROM: rd_byte = i_mem_rd_data[7:0];
      default: rd_byte = ppp_pkg::BLANK_BYTE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      oe_r <= 1'b0;
      dout_r <= 8'hFF;
    end else begin
      oe_r <= prog_mode_r & ~i_oe_n;
      dout_r <= rd_byte;
    end
  end

  assign o_data = dout_r;
  assign o_data_oe = oe_r;
  assign o_ready_busy_n = rdy_r;
  assign o_prog_mode = prog_mode_r;
  assign o_fuse_high_eff = eff_high_r;
  assign o_fuse_low_eff = eff_low_r;
  assign o_eeprom_keep = keep_r;
  assign o_clock_output_en = clock_output_fuse_r;
  assign o_rc_trim_register = trim_r;
  assign o_op_start = start_r;
  assign o_op_kind = kind_r;
  assign o_op_page = page_r;
  assign o_mem_addr = addr_r;
  assign o_pb_valid = pb_out.valid;
  assign o_pb_data = pb_out.data;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_clean_rise;
    (ent_st_r == ENT_OFF) && i_hv_reset && !hv_prev_r && (pins == 4'h0);
  endsequence
  sequence s_hold8;
    (i_hv_reset && pins == 4'h0) [*8];
  endsequence

  property p_fuse_dflt;
    $past(i_rst) |-> fuse_high_r == 8'h99 && fuse_low_r == 8'h62;
  endproperty
  a_fuse_dflt: assert property (p_fuse_dflt) else $error("fuse defaults wrong");

  property p_entry_early;
    s_clean_rise ##1 s_hold8 |-> !prog_mode_r;
  endproperty
  a_entry_early: assert property (p_entry_early) else $error("entry before hold time");

  property p_entry_abort;
    (ent_st_r == ENT_WAIT && pins != 4'h0) |=> !prog_mode_r [*2];
  endproperty
  a_entry_abort: assert property (p_entry_abort) else $error("entry despite pin change");

  property p_erase_fuse;
    (wr_go && cmd_r == 8'h80) |=> $stable(fuse_high_r) && $stable(fuse_low_r);
  endproperty
  a_erase_fuse: assert property (p_erase_fuse) else $error("erase touched fuses");

  property p_lock_refuse;
    (wr_go && cmd_r == 8'h40 && !lock_r[0]) |=> $stable(fuse_high_r) && $stable(fuse_low_r);
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("fuse write while locked");

  property p_eff_hold;
    (prog_mode_r && $past(prog_mode_r) && mode_seen_r) |=> $stable(eff_high_r) || !prog_mode_r;
  endproperty
  a_eff_hold: assert property (p_eff_hold) else $error("fuses changed in session");

  property p_keep_now;
    $fell(fuse_high_r[3]) |-> ##1 o_eeprom_keep;
  endproperty
  a_keep_now: assert property (p_keep_now) else $error("eeprom keep late");

  property p_busy;
    (wr_go && cmd_r == 8'h40) |-> ##2 (!o_ready_busy_n) [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("not busy during fuse write");

  property p_oe_off;
    (i_oe_n && $past(i_oe_n)) |-> !o_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven without enable");

  property p_cmd_load;
    (xtal_rise && prog_mode_r && act == 2'h2) |=> cmd_r == $past(i_data);
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("command not loaded");

  property p_addr_hold;
    !(xtal_rise && act == 2'h0) |=> $stable(addr_r);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed unloaded");
endmodule : ppp_top
`default_nettype wire

/* File: tb_ppp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ppp_top;
  logic clk = 1'b0, rst = 1'b1, hv = 1'b0, xp = 1'b0, a0 = 1'b0, a1 = 1'b0, bs1 = 1'b0, bs2 = 1'b0;
  logic pgl = 1'b0, wr_n = 1'b1, oe_n = 1'b1, ser = 1'b0;
  logic [7:0] din = 8'h00;
  logic [7:0] dout, fh, fl, trim;
  logic oe, rdy, pm, keep, cko, st, pbv, done, pbr;
  ppp_pkg::ppp_op_e kind;
  logic [6:0] pg;
  logic [15:0] ma, rdd;
  logic [21:0] pbd;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int starts = 0;
  always #4 clk = ~clk;
  ppp_top i_ppp_top (.i_core_clk(clk), .i_rst(rst), .i_hv_reset(hv), .i_clock_input_pin(xp),
    .i_action_code_bit0(a0), .i_action_code_bit1(a1), .i_byte_select_one(bs1), .i_byte_select_two(bs2),
    .i_page_latch_strobe(pgl), .i_wr_n(wr_n), .i_oe_n(oe_n), .i_data(din), .i_serial_prog_mode(ser),
    .i_mem_rd_data(rdd), .i_op_done(done), .i_pb_ready(pbr), .o_data(dout), .o_data_oe(oe),
    .o_ready_busy_n(rdy), .o_prog_mode(pm), .o_fuse_high_eff(fh), .o_fuse_low_eff(fl), .o_eeprom_keep(keep),
    .o_clock_output_en(cko), .o_rc_trim_register(trim), .o_op_start(st), .o_op_kind(kind), .o_op_page(pg),
    .o_mem_addr(ma), .o_pb_valid(pbv), .o_pb_data(pbd));
  ppp_backend_model i_ppp_backend_model (.i_core_clk(clk), .i_rst(rst), .i_op_start(st), .i_pb_valid(pbv),
    .i_mem_addr(ma), .o_op_done(done), .o_pb_ready(pbr), .o_mem_rd_data(rdd));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim;
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [21:0] got, input logic [21:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic ld(input logic [1:0] act, input logic b1, input logic [7:0] d);
    @(negedge clk) {a1, a0} = act;
    bs1 = b1;
    din = d;
    @(negedge clk) xp = 1'b1;
    @(negedge clk) xp = 1'b0;
  endtask : ld
  task automatic wrp(input logic b2, input logic b1);
    @(negedge clk) {bs2, bs1} = {b2, b1};
    wr_n = 1'b0;
    @(negedge clk) wr_n = 1'b1;
    repeat (2) @(negedge clk);
    cmp(rdy, 1'b0);
    for (int n = 0; n < 400 && rdy !== 1'b1; n++) @(negedge clk);
    cmp(rdy, 1'b1);
  endtask : wrp
  task automatic rd(input logic b2, input logic b1, input logic [7:0] exp);
    @(negedge clk) {bs2, bs1} = {b2, b1};
    oe_n = 1'b0;
    repeat (2) @(negedge clk);
    cmp(oe, 1'b1);
    cmp(dout, exp);
    oe_n = 1'b1;
    @(negedge clk) cmp(oe, 1'b0);
  endtask : rd
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_and_entry;
    cmp({fh, fl}, 16'h9962);
    cmp(trim, 8'h80);
    cmp(cko, 1'b0);
    {a1, a0, bs1} = 3'h0;
    repeat (6) begin
      @(negedge clk) xp = 1'b1;
      @(negedge clk) xp = 1'b0;
    end
    // first attempt is spoiled by a pin change inside the hold window
    @(negedge clk) hv = 1'b1;
    repeat (3) @(negedge clk);
    bs1 = 1'b1;
    repeat (20) @(negedge clk);
    cmp(pm, 1'b0);
    bs1 = 1'b0;
    hv = 1'b0;
    @(negedge clk) hv = 1'b1;
    repeat (10) @(negedge clk);
    cmp(pm, 1'b0);
    for (int n = 0; n < 20 && pm !== 1'b1; n++) @(negedge clk);
    cmp(pm, 1'b1);
  endtask : t_reset_and_entry
  task automatic t_signature;
    ld(2'h2, 1'b0, ppp_pkg::CMD_RD_SIG);
    ld(2'h0, 1'b1, 8'h00);
    ld(2'h0, 1'b0, 8'h00);
    rd(1'b0, 1'b0, ppp_pkg::SIG_BYTE0);
    rd(1'b0, 1'b1, ppp_pkg::CAL_BYTE);
    ld(2'h0, 1'b0, 8'h02);
    rd(1'b0, 1'b0, ppp_pkg::SIG_BYTE2);
  endtask : t_signature
  task automatic t_fuses_erase_lock;
    ld(2'h2, 1'b0, ppp_pkg::CMD_WR_FUSE);
    // only the keep fuse is programmed, the rest keep their defaults
    ld(2'h1, 1'b0, 8'h91);
    wrp(1'b0, 1'b1);
    cmp(keep, 1'b1);
    cmp(fh, 8'h99);
    ld(2'h2, 1'b0, ppp_pkg::CMD_CHIP_ERASE);
    wrp(1'b0, 1'b0);
    ld(2'h2, 1'b0, ppp_pkg::CMD_RD_FUSE);
    rd(1'b1, 1'b1, 8'h91);
    ser = 1'b1;
    rd(1'b1, 1'b1, 8'hB1);
    ser = 1'b0;
    ld(2'h2, 1'b0, ppp_pkg::CMD_WR_LOCK);
    ld(2'h1, 1'b0, 8'hFE);
    wrp(1'b0, 1'b0);
    ld(2'h2, 1'b0, ppp_pkg::CMD_WR_FUSE);
    ld(2'h1, 1'b0, 8'h00);
    wrp(1'b0, 1'b0);
    ld(2'h2, 1'b0, ppp_pkg::CMD_RD_FUSE);
    rd(1'b0, 1'b0, 8'h62);
  endtask : t_fuses_erase_lock
  task automatic t_flash_page;
    ld(2'h2, 1'b0, ppp_pkg::CMD_WR_FLASH);
    ld(2'h0, 1'b1, 8'h01);
    ld(2'h0, 1'b0, 8'h45);
    ld(2'h1, 1'b0, 8'h34);
    ld(2'h1, 1'b1, 8'h12);
    ld(2'h3, 1'b0, 8'hEE);
    @(negedge clk) pgl = 1'b1;
    @(negedge clk) pgl = 1'b0;
    for (int n = 0; n < 10 && pbv !== 1'b1; n++) @(negedge clk);
    cmp(pbd, {6'h05, 8'h12, 8'h34});
    for (int n = 0; n < 20 && pbv === 1'b1; n++) @(negedge clk);
    wrp(1'b0, 1'b0);
    cmp(kind, ppp_pkg::OP_FLASH_PAGE);
    cmp(pg, 7'h05);
    ld(2'h2, 1'b0, ppp_pkg::CMD_RD_FLASH);
    rd(1'b0, 1'b1, 8'hA4);
    rd(1'b0, 1'b0, 8'h1F);
    cmp(ma, 16'h0145);
    ld(2'h2, 1'b0, ppp_pkg::CMD_RD_EEPROM);
    rd(1'b0, 1'b0, 8'h1F);
    ld(2'h2, 1'b0, ppp_pkg::CMD_WR_EEPROM);
    ld(2'h1, 1'b0, 8'h5C);
    @(negedge clk) pgl = 1'b1;
    @(negedge clk) pgl = 1'b0;
    for (int n = 0; n < 10 && pbv !== 1'b1; n++) @(negedge clk);
    cmp(pbd, {4'h0, 2'h1, 8'h00, 8'h5C});
    for (int n = 0; n < 20 && pbv === 1'b1; n++) @(negedge clk);
    wrp(1'b0, 1'b0);
    cmp(kind, ppp_pkg::OP_EE_PAGE);
    cmp(pg, 7'h51);
  endtask : t_flash_page
  task automatic t_exit;
    @(negedge clk) hv = 1'b0;
    repeat (3) @(negedge clk);
    cmp(pm, 1'b0);
    cmp(fh, 8'h91);
    cmp(fl, 8'h62);
    cmp(22'(starts), 22'd3);
  endtask : t_exit
  // erase, flash page and eeprom page each give one start pulse
  always @(negedge clk) begin
    if (st === 1'b1) begin
      starts++;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    @(negedge clk);
    t_reset_and_entry();
    t_signature();
    t_fuses_erase_lock();
    t_flash_page();
    t_exit();
    end_sim();
  end
endmodule : tb_ppp_top
`default_nettype wire
